// *** cvrc_analog_model.sv ***
// Behavioural model of the two analog comparators and their input levels
`timescale 1ns/1ps
`default_nettype none
module cvrc_analog_model
(
	input  wire logic        cmp1_power,
	input  wire logic        cmp2_power,
	input  wire logic        intref_to_positive,
	input  wire logic [5:0]  tap_numerator,
	input  wire logic [5:0]  tap_denominator,
	input  wire logic        slow,
	input  wire logic [15:0] pos1,
	input  wire logic [15:0] neg1,
	input  wire logic [15:0] pos2,
	input  wire logic [15:0] neg2,
	output var  logic        cmp1_raw,
	output var  logic        cmp2_raw
);
	// ******************************************************
	// Input levels, in steps of one 480th of the supply
	// ******************************************************
	logic [15:0] ref_level;
	logic [15:0] p1_eff;
	logic [15:0] p2_eff;
	assign ref_level = (tap_denominator == 6'h00) ? 16'h0000 :
		16'(({10'h000, tap_numerator} * 16'h01e0) / {10'h000, tap_denominator});
	assign p1_eff = intref_to_positive ? ref_level : pos1;
	assign p2_eff = intref_to_positive ? ref_level : pos2;
	// ******************************************************
	// Outputs, delayed off the clock grid so the design sees them truly async
	// ******************************************************
	initial cmp1_raw = 1'b0;
	initial cmp2_raw = 1'b0;
	// An unpowered comparator gives a low output rather than the last result
	always @(cmp1_power or p1_eff or neg1 or slow)
		cmp1_raw <= #(slow ? 37.3 : 3.1) (cmp1_power && (p1_eff > neg1));
	always @(cmp2_power or p2_eff or neg2 or slow)
		cmp2_raw <= #(slow ? 41.7 : 2.9) (cmp2_power && (p2_eff > neg2));
endmodule : cvrc_analog_model
`default_nettype wire

// *** cvrc_pkg.sv ***
// Constants and register map of the comparator and reference control block
// What this block does
// - Comparator results sit read-only at control bits 7:6; writes ignored.
// - Mode 110 routes raw comparator results to the two result pins.
// - Direction bits still enable the result pin drivers in mode 110.
// - Port data reads return zero on pins used as analog inputs.
// - Change of either comparator result sets the change flag, bit 6.
// - Interrupt request needs comparator, peripheral and global enables all set.
// - Any read or write of comparator control refreshes the stored result copy.
// - Persisting mismatch keeps setting the flag; clearing works after refresh.
// - Active comparators and their interrupt keep working in sleep, waking.
// - Mode 111 powers both comparators off.
// - Wake from sleep leaves comparator control unchanged.
// - Reset forces comparator control to zero, mode 000, pins 0..3 analog.
// - Comparators stay powered down throughout reset.
// - Reference control bit 7 powers the ladder up or down.
// - Reference control bit 6 connects the reference to its pin.
// - Reference control bit 5 selects low range when 1, high when 0.
// - Low range tap equals level over 24 of supply.
// - High range tap equals quarter supply plus level over 32.
// - Level field bits 3:0 picks 16 levels; bit 4 reads zero.
// - Result bit is 1 when positive input exceeds negative input.
// - Mode 010 feeds the internal reference to both positive inputs.
// - Reference drives its pin only with direction input and pin drive set.
package cvrc_pkg;
	// ******************************************************
	// Register offsets
	// ******************************************************
	localparam logic [7:0] cvrc_addr_intctl    = 8'h0b;
	localparam logic [7:0] cvrc_addr_intctl_hi = 8'h8b;
	localparam logic [7:0] cvrc_addr_flags     = 8'h0c;
	localparam logic [7:0] cvrc_addr_cmp       = 8'h1f;
	localparam logic [7:0] cvrc_addr_port_data = 8'h05;
	localparam logic [7:0] cvrc_addr_port_dir  = 8'h85;
	localparam logic [7:0] cvrc_addr_enables   = 8'h8c;
	localparam logic [7:0] cvrc_addr_ref       = 8'h9f;
	// ******************************************************
	// Reset values and masks
	// ******************************************************
	localparam logic [7:0] cvrc_rst_zero   = 8'h00;
	localparam logic [5:0] cvrc_rst_port_dir = 6'h3f;
	localparam logic [7:0] cvrc_ref_mask   = 8'hef;
	// ******************************************************
	// Field positions
	// ******************************************************
	localparam int cvrc_bit_c1      = 6;
	localparam int cvrc_bit_c2      = 7;
	localparam int cvrc_bit_in_switch = 3;
	localparam int cvrc_bit_flag      = 6;
	localparam int cvrc_bit_global_en = 7;
	localparam int cvrc_bit_periph_en = 6;
	localparam int cvrc_bit_ren     = 7;
	localparam int cvrc_bit_roe     = 6;
	localparam int cvrc_bit_rr      = 5;
	localparam int cvrc_pin_ref     = 2;
	localparam int cvrc_pin_r1      = 3;
	localparam int cvrc_pin_r2      = 4;
	// ******************************************************
	// Modes
	// ******************************************************
	localparam logic [2:0] cvrc_mode_reset   = 3'h0;
	localparam logic [2:0] cvrc_mode_intref  = 3'h2;
	localparam logic [2:0] cvrc_mode_outpins = 3'h6;
	localparam logic [2:0] cvrc_mode_off     = 3'h7;
	// Ladder: low range k/24, high range 8/32 + k/32, as numerator over denominator
	localparam logic [5:0] cvrc_low_den   = 6'h18;
	localparam logic [5:0] cvrc_high_den  = 6'h20;
	localparam logic [5:0] cvrc_high_base = 6'h08;
endpackage : cvrc_pkg

// *** cvrc_tb.sv ***
// Self-checking testbench of the comparator and reference control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// ******************************************************
	// Stimulus and observed signals
	// ******************************************************
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [5:0]  pin_in = 6'h00;
	logic [5:0]  port_out_data = 6'h15;
	logic        sleeping = 1'b0;
	logic        slow = 1'b0;
	logic [15:0] pos1 = 16'd100;
	logic [15:0] neg1 = 16'd100;
	logic [15:0] pos2 = 16'd100;
	logic [15:0] neg2 = 16'd300;
	logic [31:0] seed = 32'hfa77bffc;
	logic [7:0]  rv;
	logic [7:0]  v;
	int          num_errors = 0;
	int          num_checks = 0;
	logic [7:0]  rdata;
	logic        irq_request, wake_request, cmp1_power, cmp2_power, input_switch_select, intref_to_positive;
	logic [2:0]  comparator_mode_field;
	logic [5:0]  analog_pin_mask, tap_numerator, tap_denominator;
	logic        first_result_pin_out, first_result_pin_oe_n, second_result_pin_out, second_result_pin_oe_n;
	logic        reference_power_on, reference_to_pin, reference_range_select, cmp1_raw, cmp2_raw;
	logic [3:0]  reference_level_field;
	always #2.5 clock = ~clock;
	cvrc_top dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.cmp1_raw(cmp1_raw), .cmp2_raw(cmp2_raw), .pin_in(pin_in), .port_out_data(port_out_data),
		.sleeping(sleeping), .irq_request(irq_request), .wake_request(wake_request), .cmp1_power(cmp1_power),
		.cmp2_power(cmp2_power), .comparator_mode_field(comparator_mode_field),
		.input_switch_select(input_switch_select), .intref_to_positive(intref_to_positive),
		.analog_pin_mask(analog_pin_mask), .first_result_pin_out(first_result_pin_out),
		.first_result_pin_oe_n(first_result_pin_oe_n), .second_result_pin_out(second_result_pin_out),
		.second_result_pin_oe_n(second_result_pin_oe_n), .reference_power_on(reference_power_on),
		.reference_to_pin(reference_to_pin), .reference_range_select(reference_range_select),
		.reference_level_field(reference_level_field), .tap_numerator(tap_numerator),
		.tap_denominator(tap_denominator));
	cvrc_analog_model partner (.cmp1_power(cmp1_power), .cmp2_power(cmp2_power),
		.intref_to_positive(intref_to_positive), .tap_numerator(tap_numerator), .tap_denominator(tap_denominator),
		.slow(slow), .pos1(pos1), .neg1(neg1), .pos2(pos2), .neg2(neg2), .cmp1_raw(cmp1_raw), .cmp2_raw(cmp2_raw));
	// ******************************************************
	// Helpers
	// ******************************************************
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	function automatic logic [5:0] exp_num(input logic [7:0] r);
		return r[5] ? {2'h0, r[3:0]} : cvrc_pkg::cvrc_high_base + {2'h0, r[3:0]};
	endfunction : exp_num
	function automatic logic [5:0] exp_den(input logic [7:0] r);
		return r[5] ? cvrc_pkg::cvrc_low_den : cvrc_pkg::cvrc_high_den;
	endfunction : exp_den
	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", name, exp, got);
			num_errors++;
		end
	endtask : check
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr_reg
	// Read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		check(name, exp, d);
	endtask : rd_chk
	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : settle
	// Bounded wait; the slow comparator response plus two sync stages fits well inside it
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq_request !== 1'b1 && n < 40)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		if (irq_request !== 1'b1)
		begin
			$display("Error irq_request expected 1 seen %b", irq_request);
			num_errors++;
			print_verdict();
		end
	endtask : wait_irq
	task automatic end_test(input string name);
		$display("Test %s finished, mismatches so far %0d", name, num_errors);
	endtask : end_test
	// ******************************************************
	// Main sequence
	// ******************************************************
	initial
	begin
		@(posedge clock);
		#1;
		check("power_in_reset", 8'h00, {6'h0, cmp2_power, cmp1_power});
		@(posedge clock);
		rst <= 1'b0;
		rd_chk("comparator_control", cvrc_pkg::cvrc_addr_cmp, 8'h00);
		rd_chk("port_a_direction", cvrc_pkg::cvrc_addr_port_dir, 8'h3f);
		rd_chk("reference_control", cvrc_pkg::cvrc_addr_ref, 8'h00);
		rd_chk("peripheral_flags", cvrc_pkg::cvrc_addr_flags, 8'h00);
		rd_chk("peripheral_enables", cvrc_pkg::cvrc_addr_enables, 8'h00);
		rd_chk("unmapped", 8'h44, 8'h00);
		check("outputs_reset", {2'h0, analog_pin_mask}, 8'h0f);
		check("oe_n_reset", 8'h03, {6'h0, first_result_pin_oe_n, second_result_pin_oe_n});
		end_test("reset");
		for (int i = 0; i < 14; i++)
		begin
			seed = lfsr_next(seed);
			v = (i == 0) ? 8'hff : (i == 1) ? 8'h20 : seed[7:0];
			wr_reg(cvrc_pkg::cvrc_addr_ref, v);
			rd_chk("reference_control", cvrc_pkg::cvrc_addr_ref, v & 8'hef);
			check("tap_numerator", {2'h0, exp_num(v)}, {2'h0, tap_numerator});
			check("tap_denominator", {2'h0, exp_den(v)}, {2'h0, tap_denominator});
			check("reference_bits", {v[7:5], 1'b0, v[3:0]}, {reference_power_on, reference_to_pin,
				reference_range_select, 1'b0, reference_level_field});
		end
		end_test("reference");
		for (int m = 0; m < 8; m++)
		begin
			seed = lfsr_next(seed);
			pin_in <= seed[5:0];
			wr_reg(cvrc_pkg::cvrc_addr_cmp, {4'h0, m[0], m[2:0]});
			settle(2);
			check("mode", {5'h0, m[2:0]}, {5'h0, comparator_mode_field});
			check("input_switch", {7'h0, m[0]}, {7'h0, input_switch_select});
			check("power", (m == 7) ? 8'h00 : 8'h03, {6'h0, cmp2_power, cmp1_power});
			check("intref", {7'h0, m == 2}, {7'h0, intref_to_positive});
			check("analog_mask", (m == 7) ? 8'h00 : 8'h0f, {2'h0, analog_pin_mask});
			check("result_pins", (m == 6) ? 8'h00 : 8'h01, {6'h0, first_result_pin_out, second_result_pin_out});
			rd_chk("port_a_data", cvrc_pkg::cvrc_addr_port_data,
				(m == 7) ? {2'h0, seed[5:0]} : {2'h0, seed[5:4], 4'h0});
		end
		end_test("modes");
		pos1 <= 16'd300;
		wr_reg(cvrc_pkg::cvrc_addr_port_dir, 8'h2f);
		wr_reg(cvrc_pkg::cvrc_addr_cmp, 8'hc6);
		settle(8);
		rd_chk("comparator_control", cvrc_pkg::cvrc_addr_cmp, 8'h46);
		check("result_pins", 8'h0c, {4'h0, first_result_pin_out, first_result_pin_oe_n,
			second_result_pin_out, second_result_pin_oe_n});
		pos2 <= 16'd400;
		settle(4);
		check("second_result_pin_out", 8'h01, {7'h0, second_result_pin_out});
		wr_reg(cvrc_pkg::cvrc_addr_ref, 8'h40);
		settle(2);
		check("reference_to_pin", 8'h01, {7'h0, reference_to_pin});
		wr_reg(cvrc_pkg::cvrc_addr_port_dir, 8'h2b);
		settle(2);
		check("reference_to_pin", 8'h00, {7'h0, reference_to_pin});
		end_test("outputs");
		rd_reg(cvrc_pkg::cvrc_addr_cmp, rv);
		wr_reg(cvrc_pkg::cvrc_addr_flags, 8'h00);
		wr_reg(cvrc_pkg::cvrc_addr_enables, 8'h40);
		wr_reg(cvrc_pkg::cvrc_addr_intctl, 8'hc0);
		rd_chk("peripheral_flags", cvrc_pkg::cvrc_addr_flags, 8'h00);
		slow <= 1'b1;
		pos1 <= 16'd50;
		wait_irq();
		rd_chk("peripheral_flags", cvrc_pkg::cvrc_addr_flags, 8'h40);
		wr_reg(cvrc_pkg::cvrc_addr_flags, 8'h00);
		rd_chk("peripheral_flags", cvrc_pkg::cvrc_addr_flags, 8'h40);
		rd_chk("comparator_control", cvrc_pkg::cvrc_addr_cmp, 8'h86);
		wr_reg(cvrc_pkg::cvrc_addr_flags, 8'h00);
		rd_chk("peripheral_flags", cvrc_pkg::cvrc_addr_flags, 8'h00);
		check("irq_request", 8'h00, {7'h0, irq_request});
		pos1 <= 16'd300;
		wait_irq();
		for (int i = 0; i < 8; i++)
		begin
			wr_reg(cvrc_pkg::cvrc_addr_enables, {1'b0, i[0], 6'h00});
			wr_reg(cvrc_pkg::cvrc_addr_intctl, {i[2], i[1], 6'h00});
			settle(2);
			check("irq_request", {7'h0, i == 7}, {7'h0, irq_request});
		end
		end_test("interrupt");
		@(posedge clock);
		sleeping <= 1'b1;
		settle(3);
		check("wake_request", 8'h01, {7'h0, wake_request});
		rd_chk("comparator_control", cvrc_pkg::cvrc_addr_cmp, 8'hc6);
		wr_reg(cvrc_pkg::cvrc_addr_flags, 8'h00);
		settle(2);
		check("irq_request", 8'h00, {7'h0, irq_request});
		pos2 <= 16'd100;
		wait_irq();
		check("wake_request", 8'h01, {7'h0, wake_request});
		@(posedge clock);
		sleeping <= 1'b0;
		settle(2);
		check("wake_request", 8'h00, {7'h0, wake_request});
		end_test("sleep");
		@(posedge clock);
		rst <= 1'b1;
		@(posedge clock);
		#1;
		check("power_in_reset", 8'h00, {6'h0, cmp2_power, cmp1_power});
		@(posedge clock);
		rst <= 1'b0;
		rd_reg(cvrc_pkg::cvrc_addr_cmp, rv);
		check("comparator_control", 8'h00, rv & 8'h3f);
		rd_chk("reference_control", cvrc_pkg::cvrc_addr_ref, 8'h00);
		rd_chk("port_a_direction", cvrc_pkg::cvrc_addr_port_dir, 8'h3f);
		end_test("second_reset");
		print_verdict();
	end
endmodule : testbench
`default_nettype wire

// *** cvrc_top.sv ***
// Comparator and voltage reference control logic
`timescale 1ns/1ps
`default_nettype none
module cvrc_top
(
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output var  logic [7:0] rdata,
	input  wire logic       cmp1_raw,
	input  wire logic       cmp2_raw,
	input  wire logic [5:0] pin_in,
	input  wire logic [5:0] port_out_data,
	input  wire logic       sleeping,
	output var  logic       irq_request,
	output var  logic       wake_request,
	output var  logic       cmp1_power,
	output var  logic       cmp2_power,
	output var  logic [2:0] comparator_mode_field,
	output var  logic       input_switch_select,
	output var  logic       intref_to_positive,
	output var  logic [5:0] analog_pin_mask,
	output var  logic       first_result_pin_out,
	output var  logic       first_result_pin_oe_n,
	output var  logic       second_result_pin_out,
	output var  logic       second_result_pin_oe_n,
	output var  logic       reference_power_on,
	output var  logic       reference_to_pin,
	output var  logic       reference_range_select,
	output var  logic [3:0] reference_level_field,
	output var  logic [5:0] tap_numerator,
	output var  logic [5:0] tap_denominator
);
	// ******************************************************
	// Registers
	// ******************************************************
	logic [3:0] cmp_ctl;
	logic [7:0] intctl;
	logic       comparator_change_flag;
	logic       comparator_irq_enable;
	logic [5:0] port_a_direction;
	logic [7:0] refctl;
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] stored;
	logic [5:0] pin_s1;
	logic [5:0] pin_s2;
	logic       hit_cmp;
	logic       mismatch;
	logic [2:0] next_mode;
	logic [5:0] next_analog;

	function automatic logic [5:0] analog_of(input logic [2:0] m);
		// Pins 0..3 are comparator inputs except when comparators are off
		if (m == cvrc_pkg::cvrc_mode_off)
			analog_of = 6'h00;
		else
			analog_of = 6'h0f;
	endfunction : analog_of

	assign hit_cmp   = (addr == cvrc_pkg::cvrc_addr_cmp) && (wr || rd);
	assign mismatch  = (sync2 != stored);
	assign next_mode = cmp_ctl[2:0];
	assign next_analog = analog_of(next_mode);

	// ******************************************************
	// Synchronisers
	// ******************************************************
	always_ff @(posedge clock)
	begin
		sync1 <= {cmp2_raw, cmp1_raw};
		sync2 <= sync1;
		pin_s1 <= pin_in;
		pin_s2 <= pin_s1;
	end

	// ******************************************************
	// Register writes
	// ******************************************************
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			cmp_ctl <= 4'h0;
			intctl <= cvrc_pkg::cvrc_rst_zero;
			comparator_irq_enable <= 1'b0;
			port_a_direction <= cvrc_pkg::cvrc_rst_port_dir;
			refctl <= cvrc_pkg::cvrc_rst_zero;
		end
		else if (wr)
		begin
			case (addr)
				cvrc_pkg::cvrc_addr_cmp: cmp_ctl <= wdata[3:0];
				cvrc_pkg::cvrc_addr_intctl, cvrc_pkg::cvrc_addr_intctl_hi: intctl <= wdata;
				cvrc_pkg::cvrc_addr_enables: comparator_irq_enable <= wdata[cvrc_pkg::cvrc_bit_flag];
				cvrc_pkg::cvrc_addr_port_dir: port_a_direction <= wdata[5:0];
				cvrc_pkg::cvrc_addr_ref: refctl <= wdata & cvrc_pkg::cvrc_ref_mask;
				default: ;
			endcase
		end
	end

	// ******************************************************
	// Change detect
	// ******************************************************
	always_ff @(posedge clock)
	begin
		if (rst)
			stored <= 2'h0;
		else if (hit_cmp)
			stored <= sync2;
	end

	// Set wins over a software clear in the same cycle
	always_ff @(posedge clock)
	begin
		if (rst)
			comparator_change_flag <= 1'b0;
		else if (mismatch)
			comparator_change_flag <= 1'b1;
		else if (wr && addr == cvrc_pkg::cvrc_addr_flags)
			comparator_change_flag <= wdata[cvrc_pkg::cvrc_bit_flag];
	end

	// ******************************************************
	// Read data
	// ******************************************************
	always_ff @(posedge clock)
	begin
		if (rst)
			rdata <= cvrc_pkg::cvrc_rst_zero;
		else if (rd)
		begin
			case (addr)
				cvrc_pkg::cvrc_addr_cmp: rdata <= {sync2[1], sync2[0], 2'h0, cmp_ctl};
				cvrc_pkg::cvrc_addr_intctl, cvrc_pkg::cvrc_addr_intctl_hi: rdata <= intctl;
				cvrc_pkg::cvrc_addr_flags: rdata <= {1'b0, comparator_change_flag, 6'h00};
				cvrc_pkg::cvrc_addr_enables: rdata <= {1'b0, comparator_irq_enable, 6'h00};
				cvrc_pkg::cvrc_addr_port_dir: rdata <= {2'h0, port_a_direction};
				cvrc_pkg::cvrc_addr_port_data: rdata <= {2'h0, pin_s2 & ~next_analog};
				cvrc_pkg::cvrc_addr_ref: rdata <= refctl;
				default: rdata <= cvrc_pkg::cvrc_rst_zero;
			endcase
		end
		else
			rdata <= cvrc_pkg::cvrc_rst_zero;
	end

	// ******************************************************
	// Interrupt and power
	// ******************************************************
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			irq_request <= 1'b0;
			wake_request <= 1'b0;
			cmp1_power <= 1'b0;
			cmp2_power <= 1'b0;
		end
		else
		begin
			irq_request <= comparator_change_flag && comparator_irq_enable
				&& intctl[cvrc_pkg::cvrc_bit_periph_en] && intctl[cvrc_pkg::cvrc_bit_global_en];
			// Wake needs only the local enable; sleep does not gate the comparators
			wake_request <= sleeping && comparator_change_flag && comparator_irq_enable;
			cmp1_power <= (next_mode != cvrc_pkg::cvrc_mode_off);
			cmp2_power <= (next_mode != cvrc_pkg::cvrc_mode_off);
		end
	end

	// ******************************************************
	// Mode and pin outputs
	// ******************************************************
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			comparator_mode_field <= cvrc_pkg::cvrc_mode_reset;
			input_switch_select <= 1'b0;
			intref_to_positive <= 1'b0;
			analog_pin_mask <= 6'h0f;
			first_result_pin_out <= 1'b0;
			second_result_pin_out <= 1'b0;
			first_result_pin_oe_n <= 1'b1;
			second_result_pin_oe_n <= 1'b1;
			reference_to_pin <= 1'b0;
		end
		else
		begin
			comparator_mode_field <= next_mode;
			input_switch_select <= cmp_ctl[cvrc_pkg::cvrc_bit_in_switch];
			intref_to_positive <= (next_mode == cvrc_pkg::cvrc_mode_intref);
			analog_pin_mask <= next_analog;
			// Raw path is unsynchronised by intent; it is a mux data input into a single output register
			if (next_mode == cvrc_pkg::cvrc_mode_outpins)
			begin
				first_result_pin_out <= cmp1_raw;
				second_result_pin_out <= cmp2_raw;
			end
			else
			begin
				first_result_pin_out <= port_out_data[cvrc_pkg::cvrc_pin_r1];
				second_result_pin_out <= port_out_data[cvrc_pkg::cvrc_pin_r2];
			end
			first_result_pin_oe_n <= port_a_direction[cvrc_pkg::cvrc_pin_r1];
			second_result_pin_oe_n <= port_a_direction[cvrc_pkg::cvrc_pin_r2];
			reference_to_pin <= refctl[cvrc_pkg::cvrc_bit_roe]
				&& port_a_direction[cvrc_pkg::cvrc_pin_ref];
		end
	end

	// ******************************************************
	// Reference ladder
	// ******************************************************
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			reference_power_on <= 1'b0;
			reference_range_select <= 1'b0;
			reference_level_field <= 4'h0;
			tap_numerator <= cvrc_pkg::cvrc_high_base;
			tap_denominator <= cvrc_pkg::cvrc_high_den;
		end
		else
		begin
			reference_power_on <= refctl[cvrc_pkg::cvrc_bit_ren];
			reference_range_select <= refctl[cvrc_pkg::cvrc_bit_rr];
			reference_level_field <= refctl[3:0];
			if (refctl[cvrc_pkg::cvrc_bit_rr])
			begin
				tap_numerator <= {2'h0, refctl[3:0]};
				tap_denominator <= cvrc_pkg::cvrc_low_den;
			end
			else
			begin
				tap_numerator <= cvrc_pkg::cvrc_high_base + {2'h0, refctl[3:0]};
				tap_denominator <= cvrc_pkg::cvrc_high_den;
			end
		end
	end

	// ******************************************************
	// Checks
	// ******************************************************
	a_flag_on_mismatch: assert property (@(posedge clock) disable iff (rst)
		mismatch |=> comparator_change_flag)
		else $error("flag not set on mismatch");

	a_flag_holds: assert property (@(posedge clock) disable iff (rst)
		comparator_change_flag && !(wr && addr == cvrc_pkg::cvrc_addr_flags) |=> comparator_change_flag)
		else $error("flag cleared by itself");

	// A clear only sticks once the stored copy matches the results again
	a_flag_clear: assert property (@(posedge clock) disable iff (rst)
		!mismatch && wr && addr == cvrc_pkg::cvrc_addr_flags && !wdata[cvrc_pkg::cvrc_bit_flag]
		|=> !comparator_change_flag)
		else $error("flag clear lost");

	a_refresh_copy: assert property (@(posedge clock) disable iff (rst)
		hit_cmp |=> stored == $past(sync2))
		else $error("copy not refreshed");

	a_irq_gate: assert property (@(posedge clock) disable iff (rst)
		irq_request |-> $past(comparator_irq_enable && intctl[cvrc_pkg::cvrc_bit_global_en]
			&& intctl[cvrc_pkg::cvrc_bit_periph_en]))
		else $error("irq without enables");

	a_irq_raise: assert property (@(posedge clock) disable iff (rst)
		comparator_change_flag && comparator_irq_enable && intctl[cvrc_pkg::cvrc_bit_global_en]
		&& intctl[cvrc_pkg::cvrc_bit_periph_en] |=> irq_request)
		else $error("irq missing");

	a_wake_gate: assert property (@(posedge clock) disable iff (rst)
		wake_request |-> $past(sleeping && comparator_change_flag && comparator_irq_enable))
		else $error("wake without cause");

	a_power_active: assert property (@(posedge clock) disable iff (rst)
		next_mode != cvrc_pkg::cvrc_mode_off |=> cmp1_power && cmp2_power)
		else $error("active comparator unpowered");

	a_mode_off: assert property (@(posedge clock) disable iff (rst)
		next_mode == cvrc_pkg::cvrc_mode_off |=> !cmp1_power && !cmp2_power)
		else $error("comparators on in off mode");

	a_ctl_unchanged: assert property (@(posedge clock) disable iff (rst)
		!(wr && addr == cvrc_pkg::cvrc_addr_cmp) |=> cmp_ctl == $past(cmp_ctl))
		else $error("control changed without write");

	a_ctl_write: assert property (@(posedge clock) disable iff (rst)
		wr && addr == cvrc_pkg::cvrc_addr_cmp |=> cmp_ctl == $past(wdata[3:0]))
		else $error("control write lost");

	a_read_result: assert property (@(posedge clock) disable iff (rst)
		rd && addr == cvrc_pkg::cvrc_addr_cmp |=> rdata[7:6] == $past(sync2))
		else $error("result bits wrong");

	a_raw_to_pins: assert property (@(posedge clock) disable iff (rst)
		next_mode == cvrc_pkg::cvrc_mode_outpins |=> first_result_pin_out == $past(cmp1_raw)
			&& second_result_pin_out == $past(cmp2_raw))
		else $error("result pins not raw");

	a_dir_to_oe: assert property (@(posedge clock) disable iff (rst)
		1'b1 |=> first_result_pin_oe_n == $past(port_a_direction[cvrc_pkg::cvrc_pin_r1])
			&& second_result_pin_oe_n == $past(port_a_direction[cvrc_pkg::cvrc_pin_r2]))
		else $error("pin enable not from direction");

	a_port_masked: assert property (@(posedge clock) disable iff (rst)
		rd && addr == cvrc_pkg::cvrc_addr_port_data |=> (rdata[5:0] & $past(next_analog)) == 6'h00)
		else $error("analog pin read nonzero");

	a_ref_pin: assert property (@(posedge clock) disable iff (rst)
		reference_to_pin |-> $past(port_a_direction[cvrc_pkg::cvrc_pin_ref] && refctl[cvrc_pkg::cvrc_bit_roe]))
		else $error("reference on output pin");

	a_ref_fields: assert property (@(posedge clock) disable iff (rst)
		1'b1 |=> reference_power_on == $past(refctl[cvrc_pkg::cvrc_bit_ren])
			&& reference_range_select == $past(refctl[cvrc_pkg::cvrc_bit_rr])
			&& reference_level_field == $past(refctl[3:0]))
		else $error("reference fields wrong");

	a_ref_spare_bit: assert property (@(posedge clock) disable iff (rst)
		(refctl & ~cvrc_pkg::cvrc_ref_mask) == 8'h00)
		else $error("spare reference bit set");

	a_low_range: assert property (@(posedge clock) disable iff (rst)
		refctl[cvrc_pkg::cvrc_bit_rr] |=> tap_denominator == cvrc_pkg::cvrc_low_den
			&& tap_numerator == {2'h0, $past(refctl[3:0])})
		else $error("low range tap");

	a_high_range: assert property (@(posedge clock) disable iff (rst)
		!refctl[cvrc_pkg::cvrc_bit_rr] |=> tap_denominator == cvrc_pkg::cvrc_high_den
			&& tap_numerator == cvrc_pkg::cvrc_high_base + {2'h0, $past(refctl[3:0])})
		else $error("high range tap");

	a_intref_mode: assert property (@(posedge clock) disable iff (rst)
		1'b1 |=> intref_to_positive == ($past(next_mode) == cvrc_pkg::cvrc_mode_intref))
		else $error("internal reference routing");

	a_reset_mode: assert property (@(posedge clock)
		rst |=> comparator_mode_field == cvrc_pkg::cvrc_mode_reset && !cmp1_power && !cmp2_power)
		else $error("reset state wrong");

	c_flag_set: cover property (@(posedge clock) disable iff (rst) mismatch ##1 comparator_change_flag);
	c_irq: cover property (@(posedge clock) disable iff (rst) irq_request);
	c_outpins: cover property (@(posedge clock) disable iff (rst) next_mode == cvrc_pkg::cvrc_mode_outpins);
	c_wake: cover property (@(posedge clock) disable iff (rst) wake_request);
endmodule : cvrc_top
`default_nettype wire
